// ### hw/adrf_params.svh
// Offsets, field positions, reset values and codes of the result/selection block
`ifndef ADRF_PARAMS_SVH
`define ADRF_PARAMS_SVH

// Register byte addresses
`define ADRF_OFS_SELECT    8'h7C
`define ADRF_OFS_STATUS    8'h80
`define ADRF_OFS_RES_LOW   8'h84
`define ADRF_OFS_RES_HIGH  8'h88

// Selection register fields
`define ADRF_REF_HI        7
`define ADRF_REF_LO        6
`define ADRF_LEFT_BIT      5
`define ADRF_CHAN_HI       4
`define ADRF_CHAN_LO       0
`define ADRF_SELECT_RESET  8'h00

// Status register fields
`define ADRF_DONE_BIT      0
`define ADRF_BUSY_BIT      1

// Result coding
`define ADRF_RES_WIDTH     10
`define ADRF_FULL_SCALE    1024
`define ADRF_DIFF_HALF     512
`define ADRF_SIGN_BIT      9
`define ADRF_CODE_MAX      10'h3FF
`define ADRF_DIFF_MOST_NEG 10'h200
`define ADRF_DIFF_MOST_POS 10'h1FF

// Differential range of the channel/gain field
`define ADRF_DIFF_FIRST    5'h08
`define ADRF_DIFF_LAST     5'h1D

`endif

// ### hw/adrf_pkg.sv
// Types and shared decoding for the result/selection block
`default_nettype none
`include "adrf_params.svh"
package adrf_pkg;

  typedef enum logic [1:0]
  {
    ADRF_REF_EXTERNAL = 2'h0,
    ADRF_REF_SUPPLY   = 2'h1,
    ADRF_REF_INT_1V1  = 2'h2,
    ADRF_REF_INT_2V56 = 2'h3
  } adrf_ref_t;

  typedef enum logic [1:0]
  {
    ADRF_BUS_IDLE   = 2'h1,
    ADRF_BUS_ANSWER = 2'h2
  } adrf_bus_state_t;

  // Channel/gain codes that pick a differential pair
  function automatic logic adrf_is_diff(input logic [4:0] chan);
    adrf_is_diff = (chan >= `ADRF_DIFF_FIRST) && (chan <= `ADRF_DIFF_LAST);
  endfunction

endpackage
`default_nettype wire

// ### hw/adrf_sel_latch.sv
// Holds the active reference and channel, updated while no conversion runs or as one completes
`default_nettype none
`include "adrf_params.svh"
module adrf_sel_latch
  import adrf_pkg::*;
#(
  parameter int CHAN_W = 5
)
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire adrf_pkg::adrf_ref_t pending_ref,
  input  wire logic [CHAN_W-1:0]   pending_chan,
  input  wire logic                conv_busy,
  input  wire logic                conv_done,
  output var  adrf_pkg::adrf_ref_t active_ref,
  output logic      [CHAN_W-1:0]   active_chan
);

  adrf_ref_t           next_ref;
  logic [CHAN_W-1:0]   next_chan;
  logic                boundary;

  // A running conversion keeps its settings until it completes
  assign boundary = !conv_busy || conv_done;

  always_comb
  begin
    next_ref  = active_ref;
    next_chan = active_chan;
    if (boundary)
    begin
      next_ref  = pending_ref;
      next_chan = pending_chan;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_ref  <= ADRF_REF_EXTERNAL;
      active_chan <= '0;
    end
    else
    begin
      active_ref  <= next_ref;
      active_chan <= next_chan;
    end
  end

  a_ref_hold_busy: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_busy && !conv_done) |=> (active_ref == $past(active_ref)))
    else $error("Reference changed during a conversion");

  a_chan_hold_busy: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_busy && !conv_done) |=> $stable(active_chan))
    else $error("Channel changed during a conversion");

endmodule
`default_nettype wire

// ### hw/adrf_result_format.sv
// Captures a finished code, codes it by input kind and justifies it into two bytes
`default_nettype none
`include "adrf_params.svh"
module adrf_result_format
  import adrf_pkg::*;
#(
  parameter int RES_W = `ADRF_RES_WIDTH
)
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_code,
  input  wire logic [4:0]       chan,
  input  wire logic             left,
  output logic      [RES_W-1:0] code,
  output logic      [7:0]       low_byte,
  output logic      [7:0]       high_byte
);

  logic [RES_W-1:0] next_code;
  logic [15:0]      pair;

  // Differential codes arrive offset-binary; flipping the top bit gives two's complement
  always_comb
  begin
    next_code = code;
    if (conv_done)
    begin
      next_code = conv_code;
      if (adrf_is_diff(chan))
        next_code[RES_W-1] = ~conv_code[RES_W-1];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      code <= '0;
    else
      code <= next_code;
  end

  // Justification follows the select bit at once, not the conversion
  assign pair      = left ? {code, {(16-RES_W){1'b0}}} : 16'(code);
  assign low_byte  = pair[7:0];
  assign high_byte = pair[15:8];

  a_diff_sign: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_done && adrf_is_diff(chan)) |=> (code[`ADRF_SIGN_BIT] != $past(conv_code[`ADRF_SIGN_BIT])))
    else $error("Differential sign bit not coded as two's complement");

  a_single_unsigned: assert property (@(posedge clock) disable iff (!rst_n)
    (conv_done && !adrf_is_diff(chan)) |=> (code == $past(conv_code)))
    else $error("Single-ended code not passed unsigned");

endmodule
`default_nettype wire

// ### hw/adrf_top.sv
// Result coding and input/reference selection of the converter, with its register slave
//
// Contract
// - Single-ended result is unsigned 10-bit; 0x000 ground, 0x3FF reference minus one step.
// - Single-ended code scales as input times 1024 over reference.
// - Differential code scales as difference times gain times 512 over reference.
// - Differential result is 10-bit two's complement, -512 through +511.
// - Bit 9 in the high byte is the sign of a differential result.
// - Result byte pair is valid once the conversion done flag is set.
// - Justify bit zero right-justifies; one puts upper eight bits in high byte.
// - Reference field writes during a conversion apply only after it completes.
// - Reference codes: external pin, analog supply, internal 1.1V, internal 2.56V.
// - Justify bit change shows on the result bytes immediately.
// - Channel/gain field bits 4:0 change only after the running conversion.
// - Done flag sets when a conversion finishes; writing one clears it.
//
// The Avalon-MM slave port is this design's own decision.
`default_nettype none
`include "adrf_params.svh"
module adrf_top
  import adrf_pkg::*;
#(
  parameter int RES_W = `ADRF_RES_WIDTH,
  parameter int CHAN_W = 5
)
(
  input  wire logic                CLOCK,
  input  wire logic                RST_N,
  input  wire logic [7:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  input  wire logic [3:0]          AVS_BYTEENABLE,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire logic                CONV_BUSY,
  input  wire logic                CONV_DONE,
  input  wire logic [RES_W-1:0]    CONV_CODE,
  output var  adrf_pkg::adrf_ref_t REF_SELECT,
  output logic      [CHAN_W-1:0]   CHANNEL_SELECT,
  output logic                     DIFFERENTIAL,
  output logic                     INTERNAL_REF_ON
);

  import adrf_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************

  adrf_bus_state_t   bus_state;
  adrf_bus_state_t   next_bus_state;
  logic [7:0]        input_reference_select;
  logic [7:0]        next_input_reference_select;
  logic              conversion_done_flag;
  logic              next_conversion_done_flag;
  logic [31:0]       next_readdata;
  logic              next_differential;
  logic              next_internal_ref_on;
  logic              request;
  logic              accept;
  logic              write_accept;
  logic              low_lane;
  logic              left_justify_select;
  adrf_ref_t         reference_select_field;
  logic [CHAN_W-1:0] channel_gain_select;
  logic [RES_W-1:0]  result_code;
  logic [7:0]        result_low_byte;
  logic [7:0]        result_high_byte;

  assign reference_select_field = adrf_ref_t'(input_reference_select[`ADRF_REF_HI:`ADRF_REF_LO]);
  assign left_justify_select    = input_reference_select[`ADRF_LEFT_BIT];
  assign channel_gain_select    = input_reference_select[`ADRF_CHAN_HI:`ADRF_CHAN_LO];

  // ************************************************************
  // Bus handshake
  // ************************************************************

  // Every access waits exactly one cycle, then completes
  assign request         = AVS_READ || AVS_WRITE;
  assign accept          = request && (bus_state == ADRF_BUS_ANSWER);
  assign write_accept    = AVS_WRITE && accept;
  assign low_lane        = AVS_BYTEENABLE[0];
  assign AVS_WAITREQUEST = request && (bus_state != ADRF_BUS_ANSWER);

  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      ADRF_BUS_IDLE:
        if (request)
          next_bus_state = ADRF_BUS_ANSWER;
      ADRF_BUS_ANSWER:
        next_bus_state = ADRF_BUS_IDLE;
      default:
        next_bus_state = ADRF_BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      bus_state <= ADRF_BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  // ************************************************************
  // Registers
  // ************************************************************

  always_comb
  begin
    next_input_reference_select = input_reference_select;
    if (write_accept && low_lane && (AVS_ADDRESS == `ADRF_OFS_SELECT))
      next_input_reference_select = AVS_WRITEDATA[7:0];
  end

  // A completion in the clearing cycle keeps the flag set
  always_comb
  begin
    next_conversion_done_flag = conversion_done_flag;
    if (write_accept && low_lane && (AVS_ADDRESS == `ADRF_OFS_STATUS)
        && AVS_WRITEDATA[`ADRF_DONE_BIT])
      next_conversion_done_flag = 1'b0;
    if (CONV_DONE)
      next_conversion_done_flag = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      input_reference_select <= `ADRF_SELECT_RESET;
      conversion_done_flag   <= 1'b0;
    end
    else
    begin
      input_reference_select <= next_input_reference_select;
      conversion_done_flag   <= next_conversion_done_flag;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************

  // Snapshot taken in the waiting cycle; unmapped addresses read zero
  always_comb
  begin
    next_readdata = AVS_READDATA;
    if (AVS_READ && (bus_state == ADRF_BUS_IDLE))
    begin
      next_readdata = '0;
      case (AVS_ADDRESS)
        `ADRF_OFS_SELECT:
          next_readdata[7:0] = input_reference_select;
        `ADRF_OFS_STATUS:
        begin
          next_readdata[`ADRF_DONE_BIT] = conversion_done_flag;
          next_readdata[`ADRF_BUSY_BIT] = CONV_BUSY;
        end
        `ADRF_OFS_RES_LOW:
          next_readdata[7:0] = result_low_byte;
        `ADRF_OFS_RES_HIGH:
          next_readdata[7:0] = result_high_byte;
        default:
          next_readdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_READDATA <= '0;
    else
      AVS_READDATA <= next_readdata;
  end

  // ************************************************************
  // Converter side
  // ************************************************************

  adrf_sel_latch #(
    .CHAN_W (CHAN_W)
  ) u_sel_latch (
    .clock        (CLOCK),
    .rst_n        (RST_N),
    .pending_ref  (reference_select_field),
    .pending_chan (channel_gain_select),
    .conv_busy    (CONV_BUSY),
    .conv_done    (CONV_DONE),
    .active_ref   (REF_SELECT),
    .active_chan  (CHANNEL_SELECT)
  );

  // Coding uses the channel of the conversion that just finished
  adrf_result_format #(
    .RES_W (RES_W)
  ) u_result_format (
    .clock     (CLOCK),
    .rst_n     (RST_N),
    .conv_done (CONV_DONE),
    .conv_code (CONV_CODE),
    .chan      (CHANNEL_SELECT),
    .left      (left_justify_select),
    .code      (result_code),
    .low_byte  (result_low_byte),
    .high_byte (result_high_byte)
  );

  always_comb
  begin
    next_differential    = adrf_is_diff(CHANNEL_SELECT);
    next_internal_ref_on = (REF_SELECT == ADRF_REF_INT_1V1) || (REF_SELECT == ADRF_REF_INT_2V56);
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DIFFERENTIAL    <= 1'b0;
      INTERNAL_REF_ON <= 1'b0;
    end
    else
    begin
      DIFFERENTIAL    <= next_differential;
      INTERNAL_REF_ON <= next_internal_ref_on;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  a_done_sets: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CONV_DONE |=> conversion_done_flag)
    else $error("Done flag not set by completion");

  a_done_clears: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (write_accept && low_lane && (AVS_ADDRESS == `ADRF_OFS_STATUS)
     && AVS_WRITEDATA[`ADRF_DONE_BIT] && !CONV_DONE) |=> !conversion_done_flag)
    else $error("Done flag not cleared by writing one");

  a_done_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (conversion_done_flag && !write_accept) |=> conversion_done_flag)
    else $error("Done flag dropped without a clear");

  a_wait_one: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (request && AVS_WAITREQUEST) ##1 request |-> !AVS_WAITREQUEST)
    else $error("Access not answered after one wait cycle");

  a_sel_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (write_accept && low_lane && (AVS_ADDRESS == `ADRF_OFS_SELECT))
    |=> (input_reference_select == $past(AVS_WRITEDATA[7:0])))
    else $error("Selection register write lost");

  a_ref_follows: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!CONV_BUSY [*2]) |-> (REF_SELECT == $past(reference_select_field)))
    else $error("Idle reference does not follow the register");

  a_right_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_RES_HIGH)
     && $past(!left_justify_select)) |-> (AVS_READDATA[7:0] == 8'($past(result_code) >> 8)))
    else $error("Right-justified high byte wrong");

  a_left_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_RES_HIGH)
     && $past(left_justify_select)) |-> (AVS_READDATA[7:0] == $past(result_code[RES_W-1:RES_W-8])))
    else $error("Left-justified high byte wrong");

  a_upper_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST) |-> (AVS_READDATA[31:8] == 24'h000000))
    else $error("Unused read bits not zero");

  a_right_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_RES_LOW)
     && $past(!left_justify_select)) |-> (AVS_READDATA[7:0] == $past(result_code[7:0])))
    else $error("Right-justified low byte wrong");

  a_left_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_RES_LOW)
     && $past(left_justify_select)) |-> (AVS_READDATA[7:0] == {$past(result_code[1:0]), 6'h00}))
    else $error("Left-justified low byte wrong");

  a_sel_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_SELECT))
    |-> (AVS_READDATA[7:0] == $past(input_reference_select)))
    else $error("Selection register read wrong");

  a_status_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS == `ADRF_OFS_STATUS))
    |-> (AVS_READDATA[`ADRF_DONE_BIT] == $past(conversion_done_flag)))
    else $error("Done flag read wrong");

  a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (AVS_READ && !AVS_WAITREQUEST && (AVS_ADDRESS != `ADRF_OFS_SELECT) && (AVS_ADDRESS != `ADRF_OFS_STATUS)
     && (AVS_ADDRESS != `ADRF_OFS_RES_LOW) && (AVS_ADDRESS != `ADRF_OFS_RES_HIGH))
    |-> (AVS_READDATA == 32'h00000000))
    else $error("Unmapped address read not zero");

  a_int_ref_on: assert property (@(posedge CLOCK) disable iff (!RST_N)
    1'b1 |=> (INTERNAL_REF_ON == $past(REF_SELECT >= ADRF_REF_INT_1V1)))
    else $error("Internal reference indication wrong");

  a_diff_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
    1'b1 |=> (DIFFERENTIAL == $past((CHANNEL_SELECT >= `ADRF_DIFF_FIRST) && (CHANNEL_SELECT <= `ADRF_DIFF_LAST))))
    else $error("Differential indication wrong");

endmodule
`default_nettype wire

// ### tb/adrf_top_bench.sv
// Self-checking bench for the result coding and selection register block
`default_nettype none
module adrf_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import adrf_pkg::*;

  logic        CLOCK;
  logic        RST_N;
  logic [7:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        CONV_BUSY;
  logic        CONV_DONE;
  logic [9:0]  CONV_CODE;
  adrf_ref_t   REF_SELECT;
  logic [4:0]  CHANNEL_SELECT;
  logic        DIFFERENTIAL;
  logic        INTERNAL_REF_ON;
  int          err_total;
  int          total_checks;
  logic [7:0]  exp_q[$];
  logic [7:0]  v;
  logic [9:0]  raw_tab[6];

  adrf_top DUT
  (
    .CLOCK           (CLOCK),
    .RST_N           (RST_N),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_BYTEENABLE  (AVS_BYTEENABLE),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST),
    .CONV_BUSY       (CONV_BUSY),
    .CONV_DONE       (CONV_DONE),
    .CONV_CODE       (CONV_CODE),
    .REF_SELECT      (REF_SELECT),
    .CHANNEL_SELECT  (CHANNEL_SELECT),
    .DIFFERENTIAL    (DIFFERENTIAL),
    .INTERNAL_REF_ON (INTERNAL_REF_ON)
  );

  always #2 CLOCK = ~CLOCK;

  // ****************************************
  // Reporting
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t port value %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // Register bus master
  // ****************************************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge CLOCK);
    AVS_ADDRESS    <= a;
    AVS_WRITEDATA  <= {24'h000000, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE      <= wr;
    AVS_READ       <= !wr;
    // Waitrequest is sampled at each rising edge; the request stands until it is low
    @(posedge CLOCK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge CLOCK);
    end
    if (n >= 20)
    begin
      err_total++;
      $display("ERROR %0t bus access never answered", $time);
      final_report();
    end
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask

  // Read results are matched against the oldest note
  always @(posedge CLOCK)
  begin
    if (RST_N === 1'b1 && AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
    begin
      total_checks++;
      if (exp_q.size() == 0)
      begin
        err_total++;
        $display("ERROR %0t read with no expectation", $time);
      end
      else if (AVS_READDATA !== {24'h000000, exp_q[0]})
      begin
        err_total++;
        $display("ERROR %0t read %h expected %h", $time, AVS_READDATA, exp_q.pop_front());
      end
      else
        void'(exp_q.pop_front());
    end
  end

  // ****************************************
  // Converter side and result checks
  // ****************************************
  task automatic conv(input logic [9:0] c, input logic end_busy);
    @(posedge CLOCK);
    CONV_DONE <= 1'b1;
    CONV_CODE <= c;
    @(posedge CLOCK);
    CONV_DONE <= 1'b0;
    CONV_CODE <= ~c;
    if (end_busy)
      CONV_BUSY <= 1'b0;
  endtask

  // Reads the pair under both justifications, flipped after capture
  task automatic check_pair(input logic [7:0] sel, input logic [9:0] sv);
    wr(8'h7C, sel & 8'hDF);
    rd(8'h84, sv[7:0]);
    rd(8'h88, {6'h00, sv[9:8]});
    wr(8'h7C, sel | 8'h20);
    rd(8'h88, sv[9:2]);
    rd(8'h84, {sv[1:0], 6'h00});
  endtask

  task automatic conv_case(input logic [7:0] sel, input logic [9:0] raw, input logic diff);
    wr(8'h7C, sel);
    repeat (2) @(posedge CLOCK);
    conv(raw, 1'b0);
    rd(8'h80, 8'h01);
    check_pair(sel, diff ? (raw ^ 10'h200) : raw);
    wr(8'h80, 8'h01);
    rd(8'h80, 8'h00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    CLOCK = 1'b0;
    RST_N = 1'b0;
    AVS_ADDRESS = 8'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'hF;
    CONV_BUSY = 1'b0;
    CONV_DONE = 1'b0;
    CONV_CODE = 10'h000;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'hCB38FBC1));
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;

    rd(8'h7C, 8'h00);
    chk({6'h00, REF_SELECT}, 8'h00);
    chk({3'h0, CHANNEL_SELECT}, 8'h00);
    chk({6'h00, DIFFERENTIAL, INTERNAL_REF_ON}, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'h84, 8'h00);
    rd(8'h88, 8'h00);
    $display("test reset values done");

    v = 8'($urandom);
    wr(8'h7C, v);
    rd(8'h7C, v);
    bus(1'b1, 8'h7C, ~v, 4'hE);
    rd(8'h7C, v);
    wr(8'h90, 8'h55);
    rd(8'h90, 8'h00);
    rd(8'h7C, v);
    $display("test register access done");

    // External pin is never driven here, so every reference may be tried
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h7C, {2'(r), 6'h03});
      repeat (3) @(posedge CLOCK);
      chk({6'h00, REF_SELECT}, 8'(r));
      chk({7'h00, INTERNAL_REF_ON}, {7'h00, r >= 2});
      chk({3'h0, CHANNEL_SELECT}, 8'h03);
    end
    $display("test reference codes done");

    wr(8'h7C, 8'h45);
    repeat (2) @(posedge CLOCK);
    CONV_BUSY <= 1'b1;
    wr(8'h7C, 8'hCD);
    rd(8'h80, 8'h02);
    repeat (3) @(posedge CLOCK);
    chk({6'h00, REF_SELECT}, 8'h01);
    chk({3'h0, CHANNEL_SELECT}, 8'h05);
    chk({7'h00, DIFFERENTIAL}, 8'h00);
    conv(10'h1A6, 1'b1);
    repeat (3) @(posedge CLOCK);
    chk({6'h00, REF_SELECT}, 8'h03);
    chk({3'h0, CHANNEL_SELECT}, 8'h0D);
    chk({6'h00, DIFFERENTIAL, INTERNAL_REF_ON}, 8'h03);
    rd(8'h80, 8'h01);
    check_pair(8'hCD, 10'h1A6);
    wr(8'h80, 8'h01);
    rd(8'h80, 8'h00);
    $display("test conversion boundary done");

    raw_tab = '{10'h070, 10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'($urandom)};
    // Differential runs use only the 2.56V internal reference
    for (int i = 0; i < 6; i++)
      conv_case(8'hED, raw_tab[i], 1'b1);
    $display("test differential codes done");

    for (int i = 0; i < 6; i++)
      conv_case({2'(i % 2), 1'b0, 5'(i)}, raw_tab[i], 1'b0);
    $display("test single ended codes done");

    repeat (4) @(posedge CLOCK);
    if (exp_q.size() != 0)
    begin
      err_total++;
      $display("ERROR %0t reads left unanswered", $time);
    end
    final_report();
  end
endmodule
`default_nettype wire
